// ==== hw/stepper_axis_parameters.sv ====
/*
  parameter set of one stepper axis: stored settings, read-back of
  position and switch status, ramp mode tracking, step/direction
  microstep expansion, chopper off-time timer and load-adaptive
  current reduction.
  assumes all inputs synchronous to clk_i and a decoder upstream that
  issues at most one parameter request per cycle.
*/
//Contract
// [RULE_01] motor idle uses standby current; 255 means full module current.
// [RULE_02] position-reached reads 1 exactly when target equals actual position.
// [RULE_03] home and both limit switch levels readable as single status bits.
// [RULE_04] each limit switch has an ignore bit; 1 ignores, 0 keeps active.
// [RULE_05] storable parameters can be pushed to nonvolatile memory on command.
// [RULE_06] rotate, stop and move commands set the ramp mode automatically.
// [RULE_07] position mode steps while positions differ, with trapezoidal ramps.
// [RULE_08] velocity mode runs continuously, changing speed at maximum acceleration.
// [RULE_09] ramps start and end at minimum speed, default zero.
// [RULE_10] resolution code 0..8 selects 1,2,4..256 microsteps per full step.
// [RULE_11] interpolation at 16 microsteps expands each step into 16 fine steps.
// [RULE_12] double stepping makes every step input edge one microstep.
// [RULE_13] two-bit blank time masks comparator during switching and ringing.
// [RULE_14] chopper mode bit: 0 spread cycle, 1 constant off time.
// [RULE_15] fast-decay comparator disable stops comparator ending fast decay.
// [RULE_16] four-bit field is hysteresis end or fast decay time by mode.
// [RULE_17] second field is hysteresis start offset or sine offset by mode.
// [RULE_18] off time lasts 12 plus 32 times setting clocks, at least 64.
// [RULE_19] off-time setting zero switches all driver transistors off.
// [RULE_20] floor bit limits current reduction to half, or quarter when set.
// [RULE_21] down-step code needs 32, 8, 2 or 1 high readings per decrement.
// [RULE_22] current reduces above threshold (hyst start + hyst + 1) times 32.
module stepper_axis_parameters (
  // clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  // parameter command port
  input  wire stepper_axis_pkg::param_req_t req_i,
  output      stepper_axis_pkg::param_rsp_t rsp_o,
  output      stepper_axis_pkg::nvm_store_t nvm_o,
  // motion commands and ramp state
  input  wire logic                       motion_valid_i,
  input  wire stepper_axis_pkg::motion_cmd_t motion_cmd_i,
  input  wire logic [31:0]                target_pos_i,
  input  wire logic [31:0]                actual_pos_i,
  input  wire logic                       motor_running_i,
  output      logic                       ramp_mode_o,
  output      logic                       position_run_o,
  output      logic                       velocity_run_o,
  output      logic [31:0]                ramp_start_speed_o,
  // switches
  input  wire logic                       home_sw_i,
  input  wire logic                       right_lim_i,
  input  wire logic                       left_lim_i,
  output      logic                       right_stop_o,
  output      logic                       left_stop_o,
  // step/direction input
  input  wire logic                       sd_mode_i,
  input  wire logic                       step_i,
  output      logic                       ustep_o,
  output      logic                       ustep_fine_o,
  output      logic [8:0]                 ustep_per_full_o,
  // chopper and current
  input  wire logic [7:0]                 max_current_i,
  input  wire logic                       off_start_i,
  output      stepper_axis_pkg::chop_cfg_t chop_cfg_o,
  output      logic                       off_phase_o,
  output      logic                       bridges_off_o,
  output      logic [7:0]                 drive_current_o,
  // load-adaptive current reduction
  input  wire logic [4:0]                 current_scale_i,
  input  wire logic [3:0]                 load_hstart_i,
  input  wire logic                       load_valid_i,
  input  wire logic [9:0]                 load_value_i,
  output      logic [4:0]                 adapt_scale_o
);
  import stepper_axis_pkg::*;

  typedef struct packed {
    param_rsp_t  rsp;
    nvm_store_t  nvm;
    logic [7:0]  standby;
    logic        right_ignore;
    logic        left_ignore;
    logic        ramp_mode;
    logic [31:0] start_speed;
    logic [3:0]  ustep_res;
    logic        interp_on;
    logic        double_on;
    chop_cfg_t   chop;
    logic        floor_quarter;
    logic [1:0]  down_step;
    logic [3:0]  load_hyst;
    logic        pos_run;
    logic        vel_run;
    logic        right_stop;
    logic        left_stop;
    logic        step_prev;
    logic [5:0]  burst;
    logic        ustep;
    logic        ustep_fine;
    logic [9:0]  off_cnt;
    logic        off_phase;
    logic        bridges_off;
    logic [7:0]  drive_current;
    logic [5:0]  above_cnt;
    logic [4:0]  scale;
  } state_t;

  state_t s_q;
  state_t s_d;

  // off interval length in clocks, clamped at the minimum
  function automatic logic [9:0] off_len(input logic [3:0] t);
    logic [9:0] n;
    n = OFF_BASE_CLKS + OFF_MULT_CLKS * {6'h00, t};
    return (n < OFF_MIN_CLKS) ? OFF_MIN_CLKS : n;
  endfunction : off_len

  // high readings needed per current decrement
  function automatic logic [5:0] down_need(input logic [1:0] code);
    case (code)
      2'h0:    return DOWN_NEED_0;
      2'h1:    return DOWN_NEED_1;
      2'h2:    return DOWN_NEED_2;
      default: return DOWN_NEED_3;
    endcase
  endfunction : down_need

  // read value, error flag on unknown number
  function automatic logic [32:0] read_par(input state_t s, input logic [7:0] p,
                                           input logic pr, input logic h,
                                           input logic r, input logic l);
    case (p)
      PAR_STANDBY_CURRENT: return 33'(s.standby);
      PAR_POS_REACHED:     return 33'(pr);
      PAR_HOME_LEVEL:      return 33'(h);
      PAR_RIGHT_LEVEL:     return 33'(r);
      PAR_LEFT_LEVEL:      return 33'(l);
      PAR_RIGHT_IGNORE:    return 33'(s.right_ignore);
      PAR_LEFT_IGNORE:     return 33'(s.left_ignore);
      PAR_RAMP_MODE:       return 33'(s.ramp_mode);
      PAR_START_SPEED:     return 33'(s.start_speed);
      PAR_USTEP_RES:       return 33'(s.ustep_res);
      PAR_INTERP_ON:       return 33'(s.interp_on);
      PAR_DOUBLE_ON:       return 33'(s.double_on);
      PAR_BLANK_TIME:      return 33'(s.chop.blank_time);
      PAR_CHOP_SCHEME:     return 33'(s.chop.scheme);
      PAR_FD_COMP_OFF:     return 33'(s.chop.fd_comp_off);
      PAR_HEND_FDTIME:     return 33'(s.chop.hend_or_fdtime);
      PAR_HSTART_OFFSET:   return 33'(s.chop.hstart_or_offset);
      PAR_OFF_TIME:        return 33'(s.chop.off_time);
      PAR_CURRENT_FLOOR:   return 33'(s.floor_quarter);
      PAR_DOWN_STEP:       return 33'(s.down_step);
      PAR_LOAD_HYST:       return 33'(s.load_hyst);
      default:             return {1'b1, 32'h0000_0000};
    endcase
  endfunction : read_par

  // largest legal write value, top bit clear when not writable
  function automatic logic [32:0] write_max(input logic [7:0] p);
    case (p)
      PAR_STANDBY_CURRENT: return {1'b1, 32'h0000_00ff};
      PAR_RIGHT_IGNORE, PAR_LEFT_IGNORE, PAR_RAMP_MODE, PAR_INTERP_ON,
      PAR_DOUBLE_ON, PAR_CHOP_SCHEME, PAR_FD_COMP_OFF,
      PAR_CURRENT_FLOOR:   return {1'b1, 32'h0000_0001};
      PAR_START_SPEED:     return {1'b1, MAX_SPEED};
      PAR_USTEP_RES:       return {1'b1, MAX_USTEP_CODE};
      PAR_BLANK_TIME, PAR_DOWN_STEP: return {1'b1, 32'h0000_0003};
      PAR_HEND_FDTIME, PAR_OFF_TIME,
      PAR_LOAD_HYST:       return {1'b1, 32'h0000_000f};
      PAR_HSTART_OFFSET:   return {1'b1, MAX_HSTART};
      default:             return {1'b0, 32'h0000_0000};
    endcase
  endfunction : write_max

  logic        pos_reached;
  logic [32:0] rd;
  logic [32:0] wmax;
  logic        wr_ok;
  logic        edge_seen;
  logic        interp_act;
  logic [10:0] load_thr;
  logic [4:0]  scale_floor;
  logic        storable;

  // next-state logic for the whole block
  always_comb begin
    s_d         = s_q;
    pos_reached = (target_pos_i == actual_pos_i); // RULE_02
    rd          = read_par(s_q, req_i.param, pos_reached, home_sw_i,
                           right_lim_i, left_lim_i); // RULE_03
    wmax        = write_max(req_i.param);
    wr_ok       = wmax[32] && (req_i.value <= wmax[31:0]);
    storable    = (req_i.param == PAR_RIGHT_IGNORE) || (req_i.param == PAR_LEFT_IGNORE)
                  || (req_i.param == PAR_START_SPEED);

    // command port: one answer per request, next cycle
    s_d.rsp       = '0;
    s_d.nvm       = '0;
    if (req_i.valid) begin
      s_d.rsp.valid = 1'b1;
      if (req_i.store) begin
        // only storable parameters reach nonvolatile memory
        s_d.rsp.error = !storable;
        s_d.rsp.value = rd[31:0];
        s_d.nvm.valid = storable; // RULE_05
        s_d.nvm.param = req_i.param;
        s_d.nvm.value = rd[31:0];
      end else if (req_i.write) begin
        // out-of-range values are refused, old setting kept
        s_d.rsp.error = !wr_ok;
        s_d.rsp.value = req_i.value;
        if (wr_ok) begin
          case (req_i.param)
            PAR_STANDBY_CURRENT: s_d.standby = req_i.value[7:0];
            PAR_RIGHT_IGNORE:    s_d.right_ignore = req_i.value[0]; // RULE_04
            PAR_LEFT_IGNORE:     s_d.left_ignore = req_i.value[0]; // RULE_04
            PAR_RAMP_MODE:       s_d.ramp_mode = req_i.value[0];
            PAR_START_SPEED:     s_d.start_speed = req_i.value; // RULE_09
            PAR_USTEP_RES:       s_d.ustep_res = req_i.value[3:0];
            PAR_INTERP_ON:       s_d.interp_on = req_i.value[0];
            PAR_DOUBLE_ON:       s_d.double_on = req_i.value[0];
            PAR_BLANK_TIME:      s_d.chop.blank_time = req_i.value[1:0]; // RULE_13
            PAR_CHOP_SCHEME:     s_d.chop.scheme = req_i.value[0]; // RULE_14
            PAR_FD_COMP_OFF:     s_d.chop.fd_comp_off = req_i.value[0]; // RULE_15
            PAR_HEND_FDTIME:     s_d.chop.hend_or_fdtime = req_i.value[3:0]; // RULE_16
            PAR_HSTART_OFFSET:   s_d.chop.hstart_or_offset = req_i.value[3:0]; // RULE_17
            PAR_OFF_TIME:        s_d.chop.off_time = req_i.value[3:0];
            PAR_CURRENT_FLOOR:   s_d.floor_quarter = req_i.value[0];
            PAR_DOWN_STEP:       s_d.down_step = req_i.value[1:0];
            PAR_LOAD_HYST:       s_d.load_hyst = req_i.value[3:0];
            default:             s_d.rsp.error = 1'b1;
          endcase
        end
      end else begin
        s_d.rsp.error = rd[32];
        s_d.rsp.value = rd[31:0];
      end
    end

    // motion commands win over a same-cycle parameter write
    if (motion_valid_i) begin
      case (motion_cmd_i)
        MOTION_MOVE_TO_POS: s_d.ramp_mode = 1'b0; // RULE_06
        default:            s_d.ramp_mode = 1'b1; // RULE_06
      endcase
    end

    // ramp generator steering
    s_d.pos_run = !s_q.ramp_mode && !pos_reached; // RULE_07
    s_d.vel_run = s_q.ramp_mode; // RULE_08

    // limit switches gated by their ignore bits
    s_d.right_stop = right_lim_i && !s_q.right_ignore; // RULE_04
    s_d.left_stop  = left_lim_i && !s_q.left_ignore; // RULE_04

    // step/direction expansion; double stepping takes both edges
    s_d.step_prev  = step_i;
    edge_seen      = sd_mode_i && ((step_i && !s_q.step_prev)
                     || (s_q.double_on && !step_i && s_q.step_prev)); // RULE_12
    interp_act     = s_q.interp_on && (s_q.ustep_res == USTEP_CODE_16); // RULE_11
    s_d.ustep      = 1'b0;
    s_d.ustep_fine = 1'b0;
    if (s_q.burst != 6'h00) begin
      s_d.ustep_fine = 1'b1; // RULE_11
      s_d.burst      = s_q.burst - 6'h01;
    end
    if (edge_seen) begin
      if (interp_act) begin
        // an edge inside a running burst extends it by INTERP_SUBSTEPS (16) fine steps
        s_d.burst = s_d.burst + INTERP_SUBSTEPS; // RULE_11
      end else begin
        s_d.ustep = 1'b1;
      end
    end

    // chopper off interval timer, zero setting holds the bridge off
    s_d.bridges_off = (s_d.chop.off_time == 4'h0); // RULE_19
    if (s_q.chop.off_time == 4'h0) begin
      s_d.off_cnt   = 10'h000;
      s_d.off_phase = 1'b0;
    end else if (off_start_i && !s_q.off_phase) begin
      s_d.off_cnt   = off_len(s_q.chop.off_time) - 10'h001; // RULE_18
      s_d.off_phase = 1'b1;
    end else if (s_q.off_phase) begin
      s_d.off_cnt   = s_q.off_cnt - 10'h001;
      s_d.off_phase = (s_q.off_cnt != 10'h000);
    end

    // idle motor falls back to standby current
    s_d.drive_current = motor_running_i ? max_current_i : s_q.standby; // RULE_01

    // load-adaptive current reduction
    load_thr    = ({7'h00, load_hstart_i} + {7'h00, s_q.load_hyst} + 11'h001)
                  * LOAD_THR_SCALE; // RULE_22
    scale_floor = s_q.floor_quarter ? (current_scale_i >> 2)
                                    : (current_scale_i >> 1); // RULE_20
    if (s_q.scale > current_scale_i) begin
      s_d.scale = current_scale_i;
    end
    if (load_valid_i) begin
      if ({1'b0, load_value_i} > load_thr) begin
        if (s_q.above_cnt + 6'h01 >= down_need(s_q.down_step)) begin // RULE_21
          s_d.above_cnt = 6'h00;
          if (s_d.scale > scale_floor) begin
            s_d.scale = s_d.scale - 5'h01; // RULE_22
          end
        end else begin
          s_d.above_cnt = s_q.above_cnt + 6'h01;
        end
      end else begin
        s_d.above_cnt = 6'h00;
      end
    end
  end

  // single state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q                       <= '0;
      s_q.standby               <= RST_STANDBY;
      s_q.start_speed           <= RST_START_SPEED;
      s_q.ustep_res             <= RST_USTEP_RES;
      s_q.chop.blank_time       <= RST_BLANK_TIME;
      s_q.chop.hend_or_fdtime   <= RST_HEND;
      s_q.chop.hstart_or_offset <= RST_HSTART;
      s_q.chop.off_time         <= RST_OFF_TIME;
      s_q.down_step             <= RST_DOWN_STEP;
      s_q.load_hyst             <= RST_LOAD_HYST;
      s_q.bridges_off           <= 1'b1;
      s_q.scale                 <= 5'h1f;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs from the state register
  assign rsp_o              = s_q.rsp;
  assign nvm_o              = s_q.nvm;
  assign ramp_mode_o        = s_q.ramp_mode;
  assign position_run_o     = s_q.pos_run;
  assign velocity_run_o     = s_q.vel_run;
  assign ramp_start_speed_o = s_q.start_speed;
  assign right_stop_o       = s_q.right_stop;
  assign left_stop_o        = s_q.left_stop;
  assign ustep_o            = s_q.ustep;
  assign ustep_fine_o       = s_q.ustep_fine;
  assign ustep_per_full_o   = 9'h001 << s_q.ustep_res; // RULE_10
  assign chop_cfg_o         = s_q.chop;
  assign off_phase_o        = s_q.off_phase;
  assign bridges_off_o      = s_q.bridges_off;
  assign drive_current_o    = s_q.drive_current;
  assign adapt_scale_o      = s_q.scale;

endmodule : stepper_axis_parameters

// ==== hw/stepper_axis_pkg.sv ====
/*
  shared constants and carriers of the axis parameter block.
  assumes a command decoder upstream that turns serial frames into
  parameter requests, and a driver stage downstream that takes the
  chopper, current and step outputs.
*/
package stepper_axis_pkg;

  // parameter numbers as seen on the command port
  localparam logic [7:0] PAR_STANDBY_CURRENT = 8'h07;
  localparam logic [7:0] PAR_POS_REACHED     = 8'h08;
  localparam logic [7:0] PAR_HOME_LEVEL      = 8'h09;
  localparam logic [7:0] PAR_RIGHT_LEVEL     = 8'h0a;
  localparam logic [7:0] PAR_LEFT_LEVEL      = 8'h0b;
  localparam logic [7:0] PAR_RIGHT_IGNORE    = 8'h0c;
  localparam logic [7:0] PAR_LEFT_IGNORE     = 8'h0d;
  localparam logic [7:0] PAR_RAMP_MODE       = 8'h80;
  localparam logic [7:0] PAR_START_SPEED     = 8'h82;
  localparam logic [7:0] PAR_USTEP_RES       = 8'h8c;
  localparam logic [7:0] PAR_INTERP_ON       = 8'ha0;
  localparam logic [7:0] PAR_DOUBLE_ON       = 8'ha1;
  localparam logic [7:0] PAR_BLANK_TIME      = 8'ha2;
  localparam logic [7:0] PAR_CHOP_SCHEME     = 8'ha3;
  localparam logic [7:0] PAR_FD_COMP_OFF     = 8'ha4;
  localparam logic [7:0] PAR_HEND_FDTIME     = 8'ha5;
  localparam logic [7:0] PAR_HSTART_OFFSET   = 8'ha6;
  localparam logic [7:0] PAR_OFF_TIME        = 8'ha7;
  localparam logic [7:0] PAR_CURRENT_FLOOR   = 8'ha8;
  localparam logic [7:0] PAR_DOWN_STEP       = 8'ha9;
  localparam logic [7:0] PAR_LOAD_HYST       = 8'haa;

  // reset values
  localparam logic [7:0]  RST_STANDBY     = 8'h00;
  localparam logic [31:0] RST_START_SPEED = 32'h0000_0000;
  localparam logic [3:0]  RST_USTEP_RES   = 4'h0;
  localparam logic [1:0]  RST_BLANK_TIME  = 2'h0;
  localparam logic [3:0]  RST_HEND        = 4'h0;
  localparam logic [3:0]  RST_HSTART      = 4'h0;
  localparam logic [3:0]  RST_OFF_TIME    = 4'h0;
  localparam logic [1:0]  RST_DOWN_STEP   = 2'h0;
  localparam logic [3:0]  RST_LOAD_HYST   = 4'h0;

  // value ranges
  localparam logic [31:0] MAX_USTEP_CODE  = 32'h0000_0008;
  localparam logic [31:0] MAX_HSTART      = 32'h0000_0008;
  localparam logic [31:0] MAX_SPEED       = 32'h7fff_ffff;

  // decoded values
  localparam logic [3:0]  USTEP_CODE_16   = 4'h4;
  localparam logic [5:0]  INTERP_SUBSTEPS = 6'h10;
  localparam logic [9:0]  OFF_BASE_CLKS   = 10'h00c;
  localparam logic [9:0]  OFF_MULT_CLKS   = 10'h020;
  localparam logic [9:0]  OFF_MIN_CLKS    = 10'h040;
  localparam logic [10:0] LOAD_THR_SCALE  = 11'h020;
  localparam logic [5:0]  DOWN_NEED_0     = 6'h20;
  localparam logic [5:0]  DOWN_NEED_1     = 6'h08;
  localparam logic [5:0]  DOWN_NEED_2     = 6'h02;
  localparam logic [5:0]  DOWN_NEED_3     = 6'h01;

  // motion commands that set the ramp mode
  typedef enum logic [1:0] {
    MOTION_ROTATE_RIGHT,
    MOTION_ROTATE_LEFT,
    MOTION_STOP,
    MOTION_MOVE_TO_POS
  } motion_cmd_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        store;
    logic [7:0]  param;
    logic [31:0] value;
  } param_req_t;

  typedef struct packed {
    logic        valid;
    logic        error;
    logic [31:0] value;
  } param_rsp_t;

  typedef struct packed {
    logic        valid;
    logic [7:0]  param;
    logic [31:0] value;
  } nvm_store_t;

  typedef struct packed {
    logic [1:0] blank_time;
    logic       scheme;
    logic       fd_comp_off;
    logic [3:0] hend_or_fdtime;
    logic [3:0] hstart_or_offset;
    logic [3:0] off_time;
  } chop_cfg_t;

endpackage : stepper_axis_pkg

// ==== sim/param_host.sv ====
/*
  host model: one parameter request at a time on the command port.
  assumes a free-running clk_i and that the bench waits out reset first.
*/
module param_host (
  // clock
  input  wire logic                         clk_i,
  // command port
  output      stepper_axis_pkg::param_req_t req_o,
  input  wire stepper_axis_pkg::param_rsp_t rsp_i,
  input  wire stepper_axis_pkg::nvm_store_t nvm_i
);
  import stepper_axis_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  initial req_o = '0;
  // one-cycle request; answer taken at the next fall
  task automatic xfer(input logic w, input logic s, input logic [7:0] p,
                      input logic [31:0] v, output param_rsp_t r, output nvm_store_t n);
    @(negedge clk_i);
    req_o = '{valid: 1'b1, write: w, store: s, param: p, value: v};
    @(negedge clk_i);
    req_o = '0;
    r = rsp_i;
    n = nvm_i;
  endtask : xfer
endmodule : param_host

// ==== sim/stepper_axis_asserts.sv ====
/*
  checker for the axis parameter block, bound to its top module.
  assumes one clock domain and the synchronous active-high reset.
*/
module stepper_axis_asserts (
  input wire logic                         clk_i,
  input wire logic                         rst_i,
  input wire stepper_axis_pkg::param_req_t req_i,
  input wire stepper_axis_pkg::param_rsp_t rsp_o,
  input wire stepper_axis_pkg::nvm_store_t nvm_o,
  input wire logic                         motion_valid_i,
  input wire stepper_axis_pkg::motion_cmd_t motion_cmd_i,
  input wire logic [31:0]                  target_pos_i,
  input wire logic [31:0]                  actual_pos_i,
  input wire logic                         motor_running_i,
  input wire logic [7:0]                   max_current_i,
  input wire logic                         ramp_mode_o,
  input wire logic                         position_run_o,
  input wire logic                         velocity_run_o,
  input wire logic                         home_sw_i,
  input wire logic                         right_lim_i,
  input wire logic                         right_stop_o,
  input wire logic [7:0]                   drive_current_o,
  input wire stepper_axis_pkg::chop_cfg_t  chop_cfg_o,
  input wire logic                         bridges_off_o
);
  import stepper_axis_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // status reads
  sequence s_rd(logic [7:0] p);
    req_i.valid && !req_i.write && !req_i.store && req_i.param == p;
  endsequence
  sequence s_store_lim;
    req_i.valid && req_i.store && req_i.param == PAR_RIGHT_IGNORE;
  endsequence
  a_run_current: assert property (motor_running_i |=> drive_current_o == $past(max_current_i))
    else $error("running current wrong");
  a_reached_read: assert property (s_rd(PAR_POS_REACHED) |=>
    rsp_o.value == {31'h0, $past(target_pos_i) == $past(actual_pos_i)})
    else $error("reached read wrong");
  a_home_read: assert property (s_rd(PAR_HOME_LEVEL) |=> rsp_o.value == {31'h0, $past(home_sw_i)})
    else $error("home level read wrong");
  a_stop_gate: assert property (!right_lim_i |=> !right_stop_o)
    else $error("right stop without switch");
  a_store_pulse: assert property (s_store_lim |=> nvm_o.valid && nvm_o.param == PAR_RIGHT_IGNORE)
    else $error("store pulse missing");
  a_motion_mode: assert property (motion_valid_i |=>
    ramp_mode_o == ($past(motion_cmd_i) != MOTION_MOVE_TO_POS))
    else $error("motion mode wrong");
  a_pos_idle: assert property (target_pos_i == actual_pos_i |=> !position_run_o)
    else $error("stepping at target");
  a_velocity_lag: assert property (velocity_run_o == $past(ramp_mode_o))
    else $error("velocity run wrong");
  a_bridges_off: assert property (bridges_off_o == (chop_cfg_o.off_time == 4'h0))
    else $error("bridges off mismatch");
endmodule : stepper_axis_asserts

bind stepper_axis_parameters stepper_axis_asserts i_chk (
  .clk_i(clk_i), .rst_i(rst_i), .req_i(req_i), .rsp_o(rsp_o), .nvm_o(nvm_o),
  .motion_valid_i(motion_valid_i), .motion_cmd_i(motion_cmd_i),
  .target_pos_i(target_pos_i), .actual_pos_i(actual_pos_i),
  .motor_running_i(motor_running_i), .max_current_i(max_current_i),
  .ramp_mode_o(ramp_mode_o), .position_run_o(position_run_o),
  .velocity_run_o(velocity_run_o), .home_sw_i(home_sw_i), .right_lim_i(right_lim_i),
  .right_stop_o(right_stop_o), .drive_current_o(drive_current_o),
  .chop_cfg_o(chop_cfg_o), .bridges_off_o(bridges_off_o));

// ==== sim/stepper_axis_parameters_tb.sv ====
/*
  testbench for the axis parameter block: host model plus directed tests.
  assumes the host model and checker compiled before this file.
*/
module stepper_axis_parameters_tb;
  import stepper_axis_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, rst_i = 1, mv = 0, run = 0, hsw = 0, rl = 0, ll = 0, sd = 0, stp = 0;
  logic offs = 0, lvld = 0;
  logic [1:0] mc = '0;
  logic [31:0] tgt = '0, act = '0;
  logic [9:0] lval = '0;
  param_req_t req;
  param_rsp_t rsp, r;
  nvm_store_t nvm, n;
  chop_cfg_t cfg;
  logic ro, pr, vr, rs, ls, us, uf, ph, bo;
  logic [31:0] ss;
  logic [8:0] upf;
  logic [7:0] dc;
  logic [4:0] sc;
  int err_count = 0, cmp_count = 0, cyc = 0, k, nu, nf;
  always #4 clk_i = ~clk_i;
  param_host i_host (.clk_i(clk_i), .req_o(req), .rsp_i(rsp), .nvm_i(nvm));
  stepper_axis_parameters i_dut (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .rsp_o(rsp),
    .nvm_o(nvm), .motion_valid_i(mv), .motion_cmd_i(motion_cmd_t'(mc)), .target_pos_i(tgt),
    .actual_pos_i(act), .motor_running_i(run), .ramp_mode_o(ro), .position_run_o(pr),
    .velocity_run_o(vr), .ramp_start_speed_o(ss), .home_sw_i(hsw), .right_lim_i(rl),
    .left_lim_i(ll), .right_stop_o(rs), .left_stop_o(ls), .sd_mode_i(sd), .step_i(stp),
    .ustep_o(us), .ustep_fine_o(uf), .ustep_per_full_o(upf), .max_current_i(8'h5a),
    .off_start_i(offs), .chop_cfg_o(cfg), .off_phase_o(ph), .bridges_off_o(bo),
    .drive_current_o(dc), .current_scale_i(5'h10), .load_hstart_i(4'h0),
    .load_valid_i(lvld), .load_value_i(lval), .adapt_scale_o(sc));
  // microstep pulse counters; hang guard
  always @(posedge clk_i) begin
    nu += int'(us === 1'b1);
    nf += int'(uf === 1'b1);
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wt(input int c);
    repeat (c) @(negedge clk_i);
  endtask : wt
  task automatic wr(input logic [7:0] p, input logic [31:0] v, input logic e);
    i_host.xfer(1'b1, 1'b0, p, v, r, n);
    chk(r.error, e);
  endtask : wr
  task automatic rd(input logic [7:0] p, input logic [31:0] v);
    i_host.xfer(1'b0, 1'b0, p, 32'h0, r, n);
    chk(r.value, v);
  endtask : rd
  // one rise, one fall
  task automatic step_pair();
    nu = 0;
    nf = 0;
    stp = 1;
    wt(24);
    stp = 0;
    wt(24);
  endtask : step_pair
  task automatic ld(input logic [9:0] v);
    lvld = 1;
    lval = v;
    wt(1);
    lvld = 0;
    wt(2);
  endtask : ld
  task automatic wrap_up();
    if (err_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  // directed sequence
  initial begin
    wt(12);
    rst_i = 0;
    rd(PAR_START_SPEED, 32'h0);
    chk(ss, 32'h0);
    wr(PAR_START_SPEED, 32'h8000_0000, 1'b1);
    wr(PAR_STANDBY_CURRENT, 32'h0000_00ff, 1'b0);
    wr(PAR_STANDBY_CURRENT, 32'h0000_0100, 1'b1);
    wt(2);
    chk(dc, 8'hff);
    run = 1;
    wt(2);
    chk(dc, 8'h5a);
    run = 0;
    tgt = 32'h5;
    act = 32'h5;
    rd(PAR_POS_REACHED, 32'h1);
    wr(PAR_POS_REACHED, 32'h1, 1'b1);
    act = 32'h6;
    rd(PAR_POS_REACHED, 32'h0);
    chk(pr, 1'b1);
    hsw = 1;
    ll = 1;
    rd(PAR_HOME_LEVEL, 32'h1);
    rd(PAR_RIGHT_LEVEL, 32'h0);
    rd(PAR_LEFT_LEVEL, 32'h1);
    rl = 1;
    wt(2);
    chk({rs, ls}, 2'b11);
    wr(PAR_RIGHT_IGNORE, 32'h1, 1'b0);
    wr(PAR_LEFT_IGNORE, 32'h1, 1'b0);
    wt(1);
    chk({rs, ls}, 2'b00);
    i_host.xfer(1'b0, 1'b1, PAR_RIGHT_IGNORE, 32'h0, r, n);
    chk({n.valid, n.param, n.value}, {1'b1, PAR_RIGHT_IGNORE, 32'h1});
    i_host.xfer(1'b0, 1'b1, PAR_STANDBY_CURRENT, 32'h0, r, n);
    chk({r.error, n.valid}, 2'b10);
    for (int i = 0; i < 4; i++) begin
      mv = 1;
      mc = 2'(i);
      wt(1);
      mv = 0;
      chk(ro, i != 3);
      wt(1);
      chk(vr, i != 3);
    end
    for (int c = 0; c < 9; c++) begin
      wr(PAR_USTEP_RES, c, 1'b0);
      chk(upf, 9'h001 << c);
    end
    wr(PAR_USTEP_RES, 32'h9, 1'b1);
    sd = 1;
    step_pair();
    chk(nu, 1);
    wr(PAR_DOUBLE_ON, 32'h1, 1'b0);
    step_pair();
    chk(nu, 2);
    wr(PAR_DOUBLE_ON, 32'h0, 1'b0);
    wr(PAR_USTEP_RES, USTEP_CODE_16, 1'b0);
    wr(PAR_INTERP_ON, 32'h1, 1'b0);
    step_pair();
    chk({nu[7:0], nf[7:0]}, 16'h0010);
    wr(PAR_BLANK_TIME, 32'h3, 1'b0);
    wr(PAR_CHOP_SCHEME, 32'h1, 1'b0);
    wr(PAR_FD_COMP_OFF, 32'h1, 1'b0);
    wr(PAR_HEND_FDTIME, 32'ha, 1'b0);
    wr(PAR_HSTART_OFFSET, 32'h8, 1'b0);
    wr(PAR_HSTART_OFFSET, 32'h9, 1'b1);
    chk(cfg, 16'b11_1_1_1010_1000_0000);
    for (int t = 1; t < 4; t += 2) begin
      wr(PAR_OFF_TIME, t, 1'b0);
      offs = 1;
      wt(1);
      offs = 0;
      k = 0;
      repeat (150) begin
        k += int'(ph === 1'b1);
        wt(1);
      end
      chk(k, (12 + 32 * t < 64) ? 64 : 12 + 32 * t);
    end
    wr(PAR_OFF_TIME, 32'h0, 1'b0);
    chk(bo, 1'b1);
    wr(PAR_DOWN_STEP, 32'h3, 1'b0);
    ld(10'd32);
    chk(sc, 5'h10);
    ld(10'd33);
    chk(sc, 5'h0f);
    wr(PAR_DOWN_STEP, 32'h2, 1'b0);
    ld(10'd40);
    chk(sc, 5'h0f);
    ld(10'd40);
    chk(sc, 5'h0e);
    wr(PAR_DOWN_STEP, 32'h3, 1'b0);
    repeat (12) ld(10'd200);
    chk(sc, 5'h08);
    wr(PAR_CURRENT_FLOOR, 32'h1, 1'b0);
    repeat (6) ld(10'd200);
    chk(sc, 5'h04);
    wrap_up();
  end
endmodule : stepper_axis_parameters_tb
